// ---- hw/xod_decoder.sv ----
// xod_decoder: recognises one slice of the integer opcodes and times them
// assumes opcode bytes come from the fetch path on the same core clock
`timescale 1ns/1ps

module xod_decoder (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic                   instr_valid,
  output logic                        instr_ready,
  input  wire logic [7:0]             op_byte0,
  input  wire logic [7:0]             op_byte1,
  input  wire logic [7:0]             op_byte2,
  input  wire logic [7:0]             nest_level,
  input  wire logic                   prot_mode,
  input  wire logic                   opsize32,
  input  wire logic                   io_slow,
  output xod_pkg::xod_op_type         decoded_op,
  output logic [xod_pkg::CW-1:0]      decoded_clocks,
  output logic                        illegal,
  output logic                        busy,
  output logic                        done
);
  xod_seq_if sq ();

  xod_pkg::xod_op_type    nxt_op;
  logic [xod_pkg::CW-1:0] nxt_clocks;
  xod_pkg::xod_op_type    op_ff;
  logic [xod_pkg::CW-1:0] clocks_ff;
  logic                   illegal_ff;
  xod_pkg::xod_size_type  size;
  logic [2:0]             reg1;
  logic                   accept;

  function automatic logic [xod_pkg::CW-1:0] by_size(
    input xod_pkg::xod_size_type s,
    input logic [xod_pkg::CW-1:0] tb,
    input logic [xod_pkg::CW-1:0] tw,
    input logic [xod_pkg::CW-1:0] td);
    logic [xod_pkg::CW-1:0] r;
    unique case (s)
      xod_pkg::XOD_SZ_BYTE: r = tb;
      xod_pkg::XOD_SZ_WORD: r = tw;
      default:              r = td;
    endcase
    return r;
  endfunction : by_size

  assign accept = instr_valid && instr_ready;
  assign reg1   = op_byte1[5:3];

  // operand size from the w bit and the current operand size
  always_comb begin
    if (!op_byte0[0]) begin
      size = xod_pkg::XOD_SZ_BYTE;
    end else if (opsize32) begin
      size = xod_pkg::XOD_SZ_DWORD;
    end else begin
      size = xod_pkg::XOD_SZ_WORD;
    end
  end

  always_comb begin
    nxt_op     = xod_pkg::XOD_NONE;
    nxt_clocks = xod_pkg::T_ONE;
    if (op_byte0 == xod_pkg::OP_ESC) begin
      if (op_byte1 == xod_pkg::OP_CFG_RD) begin
        nxt_op     = xod_pkg::XOD_CFG_READ;
        nxt_clocks = prot_mode ? xod_pkg::T_CFG_RD_PM : xod_pkg::T_ONE;
      end else if (op_byte1 == xod_pkg::OP_CFG_WR) begin
        nxt_op     = xod_pkg::XOD_CFG_WRITE;
        nxt_clocks = xod_pkg::T_ONE;
      end else if (op_byte1 == xod_pkg::OP_MUL_RR) begin
        nxt_op     = xod_pkg::XOD_SIGNED_MULTIPLY;
        nxt_clocks = opsize32 ? xod_pkg::T_MUL_D : xod_pkg::T_MUL_W;
      end
    end else if (op_byte0 == xod_pkg::OP_SX_HIGH) begin
      nxt_op     = xod_pkg::XOD_SIGN_EXTEND_TO_HIGH_WORD;
      nxt_clocks = xod_pkg::T_SX_HIGH;
    end else if (op_byte0 == xod_pkg::OP_SX_ACC) begin
      nxt_op     = xod_pkg::XOD_SIGN_EXTEND_ACCUMULATOR;
      nxt_clocks = xod_pkg::T_SX_ACC;
    end else if (op_byte0 == xod_pkg::OP_DFIX_ADD) begin
      nxt_op     = xod_pkg::XOD_DECIMAL_FIX_AFTER_ADD;
      nxt_clocks = xod_pkg::T_DFIX;
    end else if (op_byte0 == xod_pkg::OP_DFIX_SUB) begin
      nxt_op     = xod_pkg::XOD_DECIMAL_FIX_AFTER_SUB;
      nxt_clocks = xod_pkg::T_DFIX;
    end else if (op_byte0[7:3] == xod_pkg::OP_DECR_REG ||
                 (op_byte0[7:1] == xod_pkg::OP_GRP_FE &&
                  reg1 == xod_pkg::REG_DECR)) begin
      nxt_op     = xod_pkg::XOD_DECREMENT;
      nxt_clocks = xod_pkg::T_ONE;
    end else if (op_byte0[7:1] == xod_pkg::OP_GRP_F6) begin
      if (reg1 == xod_pkg::REG_DIVU) begin
        nxt_op     = xod_pkg::XOD_UNSIGNED_DIVIDE;
        nxt_clocks = by_size(size, xod_pkg::T_DIV_B, xod_pkg::T_DIV_W,
                             xod_pkg::T_DIV_D);
      end else if (reg1 == xod_pkg::REG_DIVS) begin
        nxt_op     = xod_pkg::XOD_SIGNED_DIVIDE;
        nxt_clocks = by_size(size, xod_pkg::T_DIV_B, xod_pkg::T_DIV_W,
                             xod_pkg::T_DIV_D);
      end else if (reg1 == xod_pkg::REG_MULS) begin
        nxt_op     = xod_pkg::XOD_SIGNED_MULTIPLY;
        nxt_clocks = by_size(size, xod_pkg::T_MUL_B, xod_pkg::T_MUL_W,
                             xod_pkg::T_MUL_D);
      end
    end else if (op_byte0 == xod_pkg::OP_MUL_IMM ||
                 op_byte0 == xod_pkg::OP_MUL_IMM_S) begin
      nxt_op     = xod_pkg::XOD_SIGNED_MULTIPLY;
      nxt_clocks = opsize32 ? xod_pkg::T_MULI_D : xod_pkg::T_MULI_W;
    end else if (op_byte0 == xod_pkg::OP_ENTER) begin
      nxt_op = xod_pkg::XOD_ENTER_FRAME;
      if (nest_level == 8'h00) begin
        nxt_clocks = xod_pkg::T_ENTER_L0;
      end else if (nest_level == 8'h01) begin
        nxt_clocks = xod_pkg::T_ENTER_L1;
      end else begin
        nxt_clocks = xod_pkg::T_ENTER_L1 + {1'b0, nest_level, 1'b0};
      end
    end else if (op_byte0 == xod_pkg::OP_HALT) begin
      nxt_op     = xod_pkg::XOD_STOP_EXECUTION;
      nxt_clocks = xod_pkg::T_HALT;
    end else if (op_byte0[7:1] == xod_pkg::OP_IN_FIX ||
                 op_byte0[7:1] == xod_pkg::OP_IN_VAR) begin
      nxt_op     = xod_pkg::XOD_PORT_INPUT;
      nxt_clocks = (prot_mode && io_slow) ? xod_pkg::T_IN_SLOW
                                          : xod_pkg::T_IN;
    end else if (op_byte0[7:1] == xod_pkg::OP_IN_ALT) begin
      nxt_op     = xod_pkg::XOD_PORT_INPUT;
      nxt_clocks = (prot_mode && io_slow) ? xod_pkg::T_INA_SLOW
                                          : xod_pkg::T_INA;
    end
  end

  // decoded result held until the next accepted instruction
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      op_ff     <= xod_pkg::XOD_NONE;
      clocks_ff <= '0;
    end else if (accept) begin
      op_ff     <= nxt_op;
      clocks_ff <= (nxt_op == xod_pkg::XOD_NONE) ? '0 : nxt_clocks;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= accept && (nxt_op == xod_pkg::XOD_NONE);
    end
  end

  assign sq.start = accept && (nxt_op != xod_pkg::XOD_NONE);
  assign sq.count = nxt_clocks;

  xod_seq u_seq (
    .clock (clock),
    .rstn  (rstn),
    .sq    (sq.seq)
  );

  assign instr_ready    = !sq.busy;
  assign busy           = sq.busy;
  assign done           = sq.done;
  assign decoded_op     = op_ff;
  assign decoded_clocks = clocks_ff;
  assign illegal        = illegal_ff;

  property p_cfg_read;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0 == xod_pkg::OP_ESC &&
    op_byte1 == xod_pkg::OP_CFG_RD && prot_mode
    |=> clocks_ff == xod_pkg::T_CFG_RD_PM ##11 done;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config read timing wrong");

  property p_cfg_write;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0 == xod_pkg::OP_ESC && op_byte1 == xod_pkg::OP_CFG_WR
    |=> done && op_ff == xod_pkg::XOD_CFG_WRITE;
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write not one clock");

  property p_sx_high;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0 == xod_pkg::OP_SX_HIGH |=> !done ##1 done;
  endproperty
  a_sx_high: assert property (p_sx_high)
    else $error("sign extend high word not two clocks");

  property p_sx_acc;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0 == xod_pkg::OP_SX_ACC |=> busy[*3] ##1 !busy;
  endproperty
  a_sx_acc: assert property (p_sx_acc)
    else $error("sign extend accumulator not three clocks");

  property p_dfix;
    @(posedge clock) disable iff (!rstn)
    accept && (op_byte0 == xod_pkg::OP_DFIX_ADD ||
               op_byte0 == xod_pkg::OP_DFIX_SUB)
    |=> clocks_ff == xod_pkg::T_DFIX;
  endproperty
  a_dfix: assert property (p_dfix)
    else $error("decimal fix not two clocks");

  property p_decr_short;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0[7:3] == xod_pkg::OP_DECR_REG
    |=> op_ff == xod_pkg::XOD_DECREMENT && done;
  endproperty
  a_decr_short: assert property (p_decr_short)
    else $error("short decrement wrong");

  property p_div_word;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0[7:1] == xod_pkg::OP_GRP_F6 && op_byte0[0] &&
    !opsize32 && reg1[2:1] == 2'h3
    |=> clocks_ff == xod_pkg::T_DIV_W ##28 done;
  endproperty
  a_div_word: assert property (p_div_word)
    else $error("word divide not 29 clocks");

  property p_enter;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0 == xod_pkg::OP_ENTER && nest_level > 8'h01
    |=> clocks_ff == xod_pkg::T_ENTER_L1 + {1'b0, $past(nest_level), 1'b0};
  endproperty
  a_enter: assert property (p_enter)
    else $error("frame entry count wrong");

  property p_mul_acc;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0[7:1] == xod_pkg::OP_GRP_F6 && !op_byte0[0] &&
    reg1 == xod_pkg::REG_MULS |=> clocks_ff == xod_pkg::T_MUL_B;
  endproperty
  a_mul_acc: assert property (p_mul_acc)
    else $error("byte multiply not four clocks");

  property p_mul_rr;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0 == xod_pkg::OP_ESC && op_byte1 == xod_pkg::OP_MUL_RR
    |=> clocks_ff == ($past(opsize32) ? xod_pkg::T_MUL_D : xod_pkg::T_MUL_W);
  endproperty
  a_mul_rr: assert property (p_mul_rr)
    else $error("register multiply count wrong");

  property p_mul_imm;
    @(posedge clock) disable iff (!rstn)
    accept && opsize32 && (op_byte0 == xod_pkg::OP_MUL_IMM ||
                           op_byte0 == xod_pkg::OP_MUL_IMM_S)
    |=> clocks_ff == xod_pkg::T_MULI_D;
  endproperty
  a_mul_imm: assert property (p_mul_imm)
    else $error("immediate multiply count wrong");

  property p_in_slow;
    @(posedge clock) disable iff (!rstn)
    accept && op_byte0[7:1] == xod_pkg::OP_IN_ALT && prot_mode && io_slow
    |=> clocks_ff == xod_pkg::T_INA_SLOW ##24 done;
  endproperty
  a_in_slow: assert property (p_in_slow)
    else $error("port input slow path not 25 clocks");

  c_div: cover property (@(posedge clock) disable iff (!rstn)
    done && op_ff == xod_pkg::XOD_SIGNED_DIVIDE);
  c_enter: cover property (@(posedge clock) disable iff (!rstn)
    done && op_ff == xod_pkg::XOD_ENTER_FRAME);
  c_illegal: cover property (@(posedge clock) disable iff (!rstn) illegal);
endmodule : xod_decoder

// ---- hw/xod_pkg.sv ----
// xod_pkg: opcode values, clock counts and types for the opcode timing decoder
// assumes one core clock; all counts are in core clocks on a cache hit
package xod_pkg;

  localparam int CW = 10;

  localparam logic [7:0] OP_ESC       = 8'h0F;
  localparam logic [7:0] OP_CFG_RD    = 8'h3C;
  localparam logic [7:0] OP_CFG_WR    = 8'h3D;
  localparam logic [7:0] OP_SX_HIGH   = 8'h99;
  localparam logic [7:0] OP_SX_ACC    = 8'h98;
  localparam logic [7:0] OP_DFIX_ADD  = 8'h27;
  localparam logic [7:0] OP_DFIX_SUB  = 8'h2F;
  localparam logic [6:0] OP_GRP_FE    = 7'h7F;
  localparam logic [4:0] OP_DECR_REG  = 5'h09;
  localparam logic [6:0] OP_GRP_F6    = 7'h7B;
  localparam logic [7:0] OP_ENTER     = 8'hC8;
  localparam logic [7:0] OP_HALT      = 8'hF4;
  localparam logic [7:0] OP_MUL_RR    = 8'hAF;
  localparam logic [7:0] OP_MUL_IMM   = 8'h69;
  localparam logic [7:0] OP_MUL_IMM_S = 8'h6B;
  localparam logic [6:0] OP_IN_FIX    = 7'h72;
  localparam logic [6:0] OP_IN_VAR    = 7'h76;
  localparam logic [6:0] OP_IN_ALT    = 7'h36;

  localparam logic [2:0] REG_DECR = 3'h1;
  localparam logic [2:0] REG_DIVU = 3'h6;
  localparam logic [2:0] REG_DIVS = 3'h7;
  localparam logic [2:0] REG_MULS = 3'h5;

  localparam logic [CW-1:0] T_ONE       = 10'h001;
  localparam logic [CW-1:0] T_CFG_RD_PM = 10'h00C;
  localparam logic [CW-1:0] T_SX_HIGH   = 10'h002;
  localparam logic [CW-1:0] T_SX_ACC    = 10'h003;
  localparam logic [CW-1:0] T_DFIX      = 10'h002;
  localparam logic [CW-1:0] T_DIV_B     = 10'h014;
  localparam logic [CW-1:0] T_DIV_W     = 10'h01D;
  localparam logic [CW-1:0] T_DIV_D     = 10'h02D;
  localparam logic [CW-1:0] T_MUL_B     = 10'h004;
  localparam logic [CW-1:0] T_MUL_W     = 10'h005;
  localparam logic [CW-1:0] T_MUL_D     = 10'h00F;
  localparam logic [CW-1:0] T_MULI_W    = 10'h006;
  localparam logic [CW-1:0] T_MULI_D    = 10'h010;
  localparam logic [CW-1:0] T_ENTER_L0  = 10'h00D;
  localparam logic [CW-1:0] T_ENTER_L1  = 10'h011;
  localparam logic [CW-1:0] T_HALT      = 10'h00A;
  localparam logic [CW-1:0] T_IN        = 10'h008;
  localparam logic [CW-1:0] T_IN_SLOW   = 10'h016;
  localparam logic [CW-1:0] T_INA       = 10'h00B;
  localparam logic [CW-1:0] T_INA_SLOW  = 10'h019;

  typedef enum logic [3:0] {
    XOD_NONE, XOD_CFG_READ, XOD_CFG_WRITE, XOD_SIGN_EXTEND_TO_HIGH_WORD,
    XOD_SIGN_EXTEND_ACCUMULATOR, XOD_DECIMAL_FIX_AFTER_ADD,
    XOD_DECIMAL_FIX_AFTER_SUB, XOD_DECREMENT, XOD_UNSIGNED_DIVIDE,
    XOD_SIGNED_DIVIDE, XOD_ENTER_FRAME, XOD_SIGNED_MULTIPLY,
    XOD_STOP_EXECUTION, XOD_PORT_INPUT
  } xod_op_type;

  typedef enum logic [1:0] {
    XOD_SZ_BYTE, XOD_SZ_WORD, XOD_SZ_DWORD
  } xod_size_type;

endpackage : xod_pkg

// ---- hw/xod_seq.sv ----
// xod_seq: counts out the clocks of one instruction
// assumes start only while not busy and count at least one
`timescale 1ns/1ps
module xod_seq (
  input wire logic clock,
  input wire logic rstn,
  xod_seq_if.seq   sq
);
  logic [xod_pkg::CW-1:0] left_ff;
  logic                   busy_ff;

  // busy for exactly count cycles, done in the last one
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
    end else if (sq.start) begin
      busy_ff <= 1'b1;
    end else if (sq.done) begin
      busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_ff <= '0;
    end else if (sq.start) begin
      left_ff <= sq.count;
    end else if (busy_ff) begin
      left_ff <= left_ff - xod_pkg::T_ONE;
    end
  end

  assign sq.busy = busy_ff;
  assign sq.done = busy_ff && (left_ff == xod_pkg::T_ONE);
endmodule : xod_seq

// ---- hw/xod_seq_if.sv ----
// xod_seq_if: start/count request and busy/done answer to the sequencer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface xod_seq_if;
  logic                 start;
  logic [xod_pkg::CW-1:0] count;
  logic                 busy;
  logic                 done;
  modport ctrl (output start, output count, input busy, input done);
  modport seq  (input start, input count, output busy, output done);
endinterface : xod_seq_if

// ---- test/test_x86_opcode_decode_timing.sv ----
// test_x86_opcode_decode_timing: table-driven decode and timing bench
// assumes xod_decoder on one 50 MHz core clock, async active-low reset
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t: got %0h want %0h", $time, (a), (b)); end end
module test_x86_opcode_decode_timing;
  typedef struct {
    logic [23:0]         ops;
    logic [7:0]          lvl;
    logic [2:0]          f;
    xod_pkg::xod_op_type op;
    logic [9:0]          clk;
  } xod_row_type;
  logic                         clock = 1'b0;
  logic                         rstn = 1'b0;
  logic                         instr_valid = 1'b0;
  logic                         instr_ready;
  logic [7:0]                   op_byte0 = 8'h00;
  logic [7:0]                   op_byte1 = 8'h00;
  logic [7:0]                   op_byte2 = 8'h00;
  logic [7:0]                   nest_level = 8'h00;
  logic                         prot_mode = 1'b0;
  logic                         opsize32 = 1'b0;
  logic                         io_slow = 1'b0;
  xod_pkg::xod_op_type          decoded_op;
  logic [xod_pkg::CW-1:0]       decoded_clocks;
  logic                         illegal;
  logic                         busy;
  logic                         done;
  xod_row_type                  rows[$];
  int                           errors = 0;
  int                           checked = 0;
  int                           n;
  always #10 clock = ~clock;
  xod_decoder dut (.clock(clock), .rstn(rstn), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .op_byte0(op_byte0), .op_byte1(op_byte1),
    .op_byte2(op_byte2), .nest_level(nest_level), .prot_mode(prot_mode),
    .opsize32(opsize32), .io_slow(io_slow), .decoded_op(decoded_op),
    .decoded_clocks(decoded_clocks), .illegal(illegal), .busy(busy),
    .done(done));
  task summarize;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task add(input logic [23:0] ops, input logic [7:0] lvl, input logic [2:0] f,
           input xod_pkg::xod_op_type op, input logic [9:0] clk);
    xod_row_type r;
    r = '{ops, lvl, f, op, clk};
    rows.push_back(r);
  endtask : add
  task cyc;
    @(posedge clock);
    #1;
  endtask : cyc
  task bound(input int lim);
    if (n >= lim) begin
      errors++;
      summarize();
    end
  endtask : bound
  // one accept, then busy counted until done
  task run(input xod_row_type r);
    n = 0;
    while (instr_ready !== 1'b1 && n < 600) begin cyc(); n++; end
    bound(600);
    {op_byte0, op_byte1, op_byte2} = r.ops;
    nest_level = r.lvl;
    {prot_mode, opsize32, io_slow} = r.f;
    instr_valid = 1'b1;
    cyc();
    instr_valid = 1'b0;
    `CHK(decoded_op, r.op)
    `CHK(decoded_clocks, r.clk)
    `CHK(illegal, r.clk == 10'h000)
    n = 1;
    if (r.clk != 10'h000) begin
      while (done !== 1'b1 && n < 600) begin
        `CHK(busy, 1'b1)
        cyc();
        n++;
      end
      bound(600);
      `CHK(n[9:0], r.clk)
    end
    cyc();
    `CHK(busy, 1'b0)
    `CHK(instr_ready, 1'b1)
    `CHK(illegal, 1'b0)
  endtask : run
  initial begin
    add(24'h0F3C00, 8'h00, 3'h0, xod_pkg::XOD_CFG_READ, 10'h001);
    add(24'h0F3C00, 8'h00, 3'h4, xod_pkg::XOD_CFG_READ, 10'h00C);
    add(24'h0F3D00, 8'h00, 3'h0, xod_pkg::XOD_CFG_WRITE, 10'h001);
    add(24'h0F3D00, 8'h00, 3'h4, xod_pkg::XOD_CFG_WRITE, 10'h001);
    add(24'h990000, 8'h00, 3'h4,
        xod_pkg::XOD_SIGN_EXTEND_TO_HIGH_WORD, 10'h002);
    add(24'h980000, 8'h00, 3'h0,
        xod_pkg::XOD_SIGN_EXTEND_ACCUMULATOR, 10'h003);
    add(24'h270000, 8'h00, 3'h4,
        xod_pkg::XOD_DECIMAL_FIX_AFTER_ADD, 10'h002);
    add(24'h2F0000, 8'h00, 3'h0,
        xod_pkg::XOD_DECIMAL_FIX_AFTER_SUB, 10'h002);
    add(24'hFEC800, 8'h00, 3'h0, xod_pkg::XOD_DECREMENT, 10'h001);
    add(24'hFFC800, 8'h00, 3'h6, xod_pkg::XOD_DECREMENT, 10'h001);
    add(24'h480000, 8'h00, 3'h0, xod_pkg::XOD_DECREMENT, 10'h001);
    add(24'h4F0000, 8'h00, 3'h4, xod_pkg::XOD_DECREMENT, 10'h001);
    add(24'hF6F000, 8'h00, 3'h2, xod_pkg::XOD_UNSIGNED_DIVIDE, 10'h014);
    add(24'hF7F000, 8'h00, 3'h0, xod_pkg::XOD_UNSIGNED_DIVIDE, 10'h01D);
    add(24'hF7F000, 8'h00, 3'h2, xod_pkg::XOD_UNSIGNED_DIVIDE, 10'h02D);
    add(24'hF6F800, 8'h00, 3'h0, xod_pkg::XOD_SIGNED_DIVIDE, 10'h014);
    add(24'hF7F800, 8'h00, 3'h4, xod_pkg::XOD_SIGNED_DIVIDE, 10'h01D);
    add(24'hF7F800, 8'h00, 3'h6, xod_pkg::XOD_SIGNED_DIVIDE, 10'h02D);
    add(24'hC80000, 8'h00, 3'h0, xod_pkg::XOD_ENTER_FRAME, 10'h00D);
    add(24'hC80000, 8'h01, 3'h4, xod_pkg::XOD_ENTER_FRAME, 10'h011);
    add(24'hC80000, 8'h02, 3'h0, xod_pkg::XOD_ENTER_FRAME, 10'h015);
    add(24'hC80000, 8'hFF, 3'h0, xod_pkg::XOD_ENTER_FRAME, 10'h20F);
    add(24'hF6E800, 8'h00, 3'h2, xod_pkg::XOD_SIGNED_MULTIPLY, 10'h004);
    add(24'hF7E800, 8'h00, 3'h0, xod_pkg::XOD_SIGNED_MULTIPLY, 10'h005);
    add(24'hF7E800, 8'h00, 3'h2, xod_pkg::XOD_SIGNED_MULTIPLY, 10'h00F);
    add(24'h0FAFC0, 8'h00, 3'h0, xod_pkg::XOD_SIGNED_MULTIPLY, 10'h005);
    add(24'h0FAFC0, 8'h00, 3'h2, xod_pkg::XOD_SIGNED_MULTIPLY, 10'h00F);
    add(24'h69C000, 8'h00, 3'h0, xod_pkg::XOD_SIGNED_MULTIPLY, 10'h006);
    add(24'h6BC000, 8'h00, 3'h2, xod_pkg::XOD_SIGNED_MULTIPLY, 10'h010);
    add(24'hF40000, 8'h00, 3'h0, xod_pkg::XOD_STOP_EXECUTION, 10'h00A);
    add(24'hE40000, 8'h00, 3'h1, xod_pkg::XOD_PORT_INPUT, 10'h008);
    add(24'hE50000, 8'h00, 3'h4, xod_pkg::XOD_PORT_INPUT, 10'h008);
    add(24'hED0000, 8'h00, 3'h5, xod_pkg::XOD_PORT_INPUT, 10'h016);
    add(24'hEC0000, 8'h00, 3'h0, xod_pkg::XOD_PORT_INPUT, 10'h008);
    add(24'h6C0000, 8'h00, 3'h1, xod_pkg::XOD_PORT_INPUT, 10'h00B);
    add(24'h6D0000, 8'h00, 3'h5, xod_pkg::XOD_PORT_INPUT, 10'h019);
    add(24'h6C0000, 8'h00, 3'h4, xod_pkg::XOD_PORT_INPUT, 10'h00B);
    add(24'hF6C000, 8'h00, 3'h0, xod_pkg::XOD_NONE, 10'h000);
    add(24'hFEC000, 8'h00, 3'h0, xod_pkg::XOD_NONE, 10'h000);
    repeat (16) @(posedge clock);
    #1;
    `CHK(instr_ready, 1'b1)
    `CHK(decoded_op, xod_pkg::XOD_NONE)
    `CHK(busy, 1'b0)
    `CHK(done, 1'b0)
    `CHK(decoded_clocks, 10'h000)
    `CHK(illegal, 1'b0)
    rstn = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      run(rows[i]);
      $display("test row %0d done", i);
    end
    // request held while busy waits for the spacing of count plus one
    {op_byte0, prot_mode} = {8'h99, 1'b0};
    instr_valid = 1'b1;
    cyc();
    op_byte0 = 8'h27;
    `CHK(instr_ready, 1'b0)
    cyc();
    `CHK(decoded_op, xod_pkg::XOD_SIGN_EXTEND_TO_HIGH_WORD)
    cyc();
    `CHK(instr_ready, 1'b1)
    cyc();
    instr_valid = 1'b0;
    `CHK(decoded_op, xod_pkg::XOD_DECIMAL_FIX_AFTER_ADD)
    `CHK(busy, 1'b1)
    cyc();
    `CHK(done, 1'b1)
    cyc();
    $display("test back to back done");
    // reset in mid divide clears the sequence
    {op_byte0, op_byte1, opsize32} = {8'hF7, 8'hF0, 1'b1};
    instr_valid = 1'b1;
    cyc();
    instr_valid = 1'b0;
    repeat (5) cyc();
    rstn = 1'b0;
    #1;
    `CHK(busy, 1'b0)
    `CHK(done, 1'b0)
    `CHK(instr_ready, 1'b1)
    `CHK(decoded_clocks, 10'h000)
    `CHK(decoded_op, xod_pkg::XOD_NONE)
    repeat (2) cyc();
    rstn = 1'b1;
    run(rows[6]);
    $display("test mid reset done");
    summarize();
  end
endmodule : test_x86_opcode_decode_timing
